// file: design/drk_map.vh
/*
 * Constants for the 4096 x 1 dynamic RAM core: array shape,
 * refresh row field, clock rate and the timing counts derived from it.
 * Assumes a single 100 MHz system clock drives the core.
 */
`ifndef DRK_MAP_VH
`define DRK_MAP_VH

// Array shape
`define DRK_ADDR_W      12
`define DRK_WORDS       4096
`define DRK_ROW_LSB     0
`define DRK_ROW_MSB     5
`define DRK_ROW_W       6
`define DRK_ROWS        64

// Clock rate
`define DRK_CLK_MHZ     100
`define DRK_NS_PER_US   1000

// Access delay from chip-enable rise to valid output (longest time)
`define DRK_ACCESS_NS   280
`define DRK_ACCESS_CYC  ((`DRK_ACCESS_NS * `DRK_CLK_MHZ) / `DRK_NS_PER_US)
`define DRK_ACC_CNT_W   5

// Retention interval and its coarse age ticks
`define DRK_REFRESH_MS  2
`define DRK_US_PER_MS   1000
`define DRK_AGE_TICKS   16
`define DRK_AGE_W       5
`define DRK_AGE_LIMIT   5'h10
`define DRK_TICK_CNT_W  18

// Reset values
`define DRK_BIT_RST     1'b0
`define DRK_OE_N_RST    1'b1
`define DRK_AGE_RST     5'h00
`define DRK_ACC_RST     5'h00

`endif

// file: design/drk_dram_core.v
/*
 * 4096 x 1 dynamic RAM core, clocked by the system clock and driven by
 * a chip-enable pulse that frames every access.
 * Assumes all pin inputs are asynchronous to ref_clk_i; each passes a
 * two-flop synchroniser. The far side schedules refresh and keeps its
 * own setup, hold and write-enable ordering.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drk_map.vh"

////////////////////////////////////////////////////////////////////////
// Contract
// - Stores 4096 one-bit words chosen by twelve address lines.
// - Reading never alters the stored bit.
// - Touching one row refreshes all 64 bits of that row.
// - Refresh works whether chip select is low or high.
// - Accesses only while chip enable high; low means idle precharge.
// - Chip select low by enable rise; device registers it then.
// - Data in, data out and write act only if registered select low.
// - Address stable by enable rise; device latches it then.
// - Write enable high reads, low writes.
// - Data input ignored in read mode.
// - Write data taken while enable high; controller holds it.
// - Output floats when enable low or select high.
// - Output shows the inverse of the written bit.
module drk_dram_core #(
    parameter REFRESH_CYCLES = `DRK_REFRESH_MS * `DRK_US_PER_MS * `DRK_CLK_MHZ
) (
    // Clock and reset
    input  wire                     ref_clk_i,
    input  wire                     resetn_i,
    // Memory pins from the controller
    input  wire                     chip_enable_i,
    input  wire                     chip_select_n_i,
    input  wire                     write_enable_n_i,
    input  wire [`DRK_ADDR_W-1:0]   address_lines_i,
    input  wire                     data_in_i,
    // Three-state data output
    output reg                      data_out_o,
    output reg                      data_out_oe_n_o,
    // Retention status
    output reg                      retention_lost_o
);

    localparam integer TICK_PERIOD = REFRESH_CYCLES / `DRK_AGE_TICKS;
    localparam integer TICK_LAST_I = TICK_PERIOD - 1;
    localparam integer ACC_LAST_I  = `DRK_ACCESS_CYC - 1;
    // Counts cut to their counter widths on purpose
    localparam [`DRK_TICK_CNT_W-1:0] TICK_LAST =
        TICK_LAST_I[`DRK_TICK_CNT_W-1:0];
    localparam [`DRK_ACC_CNT_W-1:0] ACC_LAST =
        ACC_LAST_I[`DRK_ACC_CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage is read only by the second

    wire                    ce_s_q;
    wire                    cs_n_s_q;
    wire                    we_n_s_q;
    wire                    din_s_q;
    wire [`DRK_ADDR_W-1:0]  addr_s_q;
    reg                     ce_d1_q;

    drk_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_ce (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (chip_enable_i),
        .sync_o    (ce_s_q)
    );

    drk_sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_cs (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (chip_select_n_i),
        .sync_o    (cs_n_s_q)
    );

    drk_sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_we (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (write_enable_n_i),
        .sync_o    (we_n_s_q)
    );

    drk_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_din (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (data_in_i),
        .sync_o    (din_s_q)
    );

    // Address bits settle well before the synced enable rise, so
    // bitwise syncing cannot mix two addresses at the latch
    drk_sync2 #(
        .W       (`DRK_ADDR_W),
        .RST_VAL ({`DRK_ADDR_W{1'b0}})
    ) u_sync_addr (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (address_lines_i),
        .sync_o    (addr_s_q)
    );

    // Delayed synced enable for the rise detector
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ce_d1_q <= 1'b0;
        end else begin
            ce_d1_q <= ce_s_q;
        end
    end

    wire ce_rise = ce_s_q & ~ce_d1_q;

    ////////////////////////////////////////////////////////////////////
    // Address and select registers, loaded at the enable rise only

    reg [`DRK_ADDR_W-1:0]   addr_q;
    reg                     cs_n_q;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            addr_q <= {`DRK_ADDR_W{1'b0}};
            cs_n_q <= 1'b1;
        end else if (ce_rise) begin
            addr_q <= addr_s_q;
            cs_n_q <= cs_n_s_q;
        end
    end

    // Active cycle: enable high and past the rise, so the latched
    // address is in use. Precharge while enable is low.
    wire active   = ce_s_q & ce_d1_q;
    wire selected = active & ~cs_n_q;
    wire wr_now   = selected & ~we_n_s_q;

    ////////////////////////////////////////////////////////////////////
    // Storage array; no reset, contents are undefined at power-up

    reg mem_q [0:`DRK_WORDS-1];

    // Din is not latched at the enable rise: sampled each write cycle,
    // so the last value before write enable rises or enable falls is the one kept.
    always @(posedge ref_clk_i) begin
        if (wr_now) begin
            mem_q[addr_q] <= din_s_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path: access delay counter and output hold

    reg [`DRK_ACC_CNT_W-1:0]  acc_cnt_q;
    reg                       acc_done_q;
    reg                       rd_valid_q;
    reg                       rd_bit_q;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            acc_cnt_q  <= `DRK_ACC_RST;
            acc_done_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_bit_q   <= `DRK_BIT_RST;
        end else if (!ce_s_q) begin
            acc_cnt_q  <= `DRK_ACC_RST;
            acc_done_q <= 1'b0;
            rd_valid_q <= 1'b0;
        end else if (active && !acc_done_q) begin
            if (acc_cnt_q == ACC_LAST) begin
                acc_done_q <= 1'b1;
                // Write mode at the delay end means a plain write:
                // no read data is ever presented for it.
                if (selected && we_n_s_q) begin
                    rd_valid_q <= 1'b1;
                    rd_bit_q   <= ~mem_q[addr_q];
                end
            end else begin
                acc_cnt_q <= acc_cnt_q + 1'b1;
            end
        end
    end

    // Read leaves the cell untouched: the array is written only by
    // wr_now, and the input is ignored in read mode.

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            data_out_o      <= `DRK_BIT_RST;
            data_out_oe_n_o <= `DRK_OE_N_RST;
        end else begin
            data_out_o      <= rd_bit_q;
            // Float once enable falls or select was high
            data_out_oe_n_o <= ~(ce_s_q & ~cs_n_q & rd_valid_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Row retention: coarse age per row, cleared by any access.
    // Ages are kept in ticks of one sixteenth of the interval, so a
    // lost row is flagged up to one tick early; trading accuracy for
    // a small counter per row.

    reg [`DRK_TICK_CNT_W-1:0] tick_cnt_q;
    reg                       tick_q;
    wire [`DRK_ROWS-1:0]      row_lost;
    wire                      lost_any = |row_lost;

    wire [`DRK_ROW_W-1:0] row =
        addr_q[`DRK_ROW_MSB:`DRK_ROW_LSB];
    // Active cycle marks its row; select plays no part
    wire [`DRK_ROWS-1:0] row_hit =
        {{(`DRK_ROWS-1){1'b0}}, active} << row;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            tick_cnt_q <= {`DRK_TICK_CNT_W{1'b0}};
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= {`DRK_TICK_CNT_W{1'b0}};
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `DRK_ROWS; g = g + 1) begin : g_row
            drk_row_age u_age (
                .ref_clk_i (ref_clk_i),
                .resetn_i  (resetn_i),
                .touch_i   (row_hit[g]),
                .tick_i    (tick_q),
                .lost_o    (row_lost[g])
            );
        end
    endgenerate

    // Sticky until reset; shows the controller broke the interval
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            retention_lost_o <= 1'b0;
        end else if (lost_any) begin
            retention_lost_o <= 1'b1;
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for pin inputs; the first stage feeds
// only the second, never any logic.

module drk_sync2 #(
    parameter            W       = 1,
    parameter [W-1:0]    RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input  wire            ref_clk_i,
    input  wire            resetn_i,
    // Pin side and clock side
    input  wire [W-1:0]    async_i,
    output wire [W-1:0]    sync_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

////////////////////////////////////////////////////////////////////////
// Age of one row in ticks; saturates so a lost row stays
// flagged until it is touched again.

module drk_row_age (
    // Clock and reset
    input  wire    ref_clk_i,
    input  wire    resetn_i,
    // Row events
    input  wire    touch_i,
    input  wire    tick_i,
    // Age at the limit
    output wire    lost_o
);

    localparam [`DRK_AGE_W-1:0] AGE_LIMIT = `DRK_AGE_LIMIT;

    reg [`DRK_AGE_W-1:0] age_q;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            age_q <= `DRK_AGE_RST;
        end else if (touch_i) begin
            // Access wins over a tick in the same cycle
            age_q <= `DRK_AGE_RST;
        end else if (tick_i && age_q != AGE_LIMIT) begin
            age_q <= age_q + 1'b1;
        end
    end

    assign lost_o = (age_q == AGE_LIMIT);

endmodule
`default_nettype wire

// file: tb/drk_dram_asserts.sv
/* Pin checker for the DRAM core.
   Assumes select is held for each whole enable pulse. */
`timescale 1ns/10ps
`default_nettype none
module drk_dram_asserts #(
    parameter REFRESH_CYCLES = 200000
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Core pins
    input wire logic chip_enable_i,
    input wire logic chip_select_n_i,
    input wire logic write_enable_n_i,
    input wire logic data_out_o,
    input wire logic data_out_oe_n_o,
    input wire logic retention_lost_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    a_read_delay:
    assert property ($rose(chip_enable_i) && !chip_select_n_i &&
        write_enable_n_i |-> ##20 data_out_oe_n_o ##[10:16] !data_out_oe_n_o)
        else $error("read data not driven on time");
    a_write_quiet:
    assert property ($rose(chip_enable_i) && !write_enable_n_i
        |-> ##36 data_out_oe_n_o) else $error("write drove the output");
    a_select_gate:
    assert property ($fell(data_out_oe_n_o) |-> !chip_select_n_i)
        else $error("output driven while deselected");
    a_enable_cause:
    assert property ($fell(data_out_oe_n_o) |-> $past(chip_enable_i, 30))
        else $error("output driven without an access");
    a_hold_drive:
    assert property (!data_out_oe_n_o && chip_enable_i |=> !data_out_oe_n_o)
        else $error("output released during the pulse");
    a_data_steady:
    assert property (!data_out_oe_n_o && !$past(data_out_oe_n_o)
        |-> $stable(data_out_o)) else $error("read data changed");
    a_ce_release:
    assert property ($fell(chip_enable_i) |-> ##[1:4] data_out_oe_n_o)
        else $error("output not floated after the pulse");
    a_lost_sticky:
    assert property ($rose(retention_lost_o) |=> retention_lost_o [*8])
        else $error("retention flag dropped");

    c_read: cover property ($fell(data_out_oe_n_o));
    c_write: cover property ($rose(chip_enable_i) && !write_enable_n_i);
    c_lost: cover property ($rose(retention_lost_o));
endmodule
bind drk_dram_core drk_dram_asserts #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
    .ref_clk_i, .resetn_i, .chip_enable_i, .chip_select_n_i,
    .write_enable_n_i, .data_out_o, .data_out_oe_n_o, .retention_lost_o);
`default_nettype wire

// file: tb/drk_ctrl_model.sv
/* Memory controller model driving the DRAM core pins.
   Assumes each call starts just after a falling clock edge. */
`timescale 1ns/10ps
`default_nettype none
module drk_ctrl_model (
    // Clock and core output
    input  wire logic        ref_clk_i,
    input  wire logic        data_out_i,
    input  wire logic        data_out_oe_n_i,
    // Pins to the core
    output var  logic        chip_enable_o,
    output var  logic        chip_select_n_o,
    output var  logic        write_enable_n_o,
    output var  logic [11:0] address_lines_o,
    output var  logic        data_in_o
);
    initial {chip_enable_o, chip_select_n_o, write_enable_n_o,
        address_lines_o, data_in_o} = {3'b011, 12'h000, 1'b0};

    // One framed pulse; r writes only once the read data is out
    task automatic access(input logic [11:0] a, input logic s, w, r, d,
                          output logic q, oe_n);
        address_lines_o = a;
        chip_select_n_o = s;
        write_enable_n_o = !(w && !r);
        data_in_o = d;
        repeat (3) @(negedge ref_clk_i);
        chip_enable_o = 1'b1;
        repeat (36) @(negedge ref_clk_i);
        // A floating output reads as the inverse of the last value
        q = data_out_oe_n_i ? ~data_out_i : data_out_i;
        oe_n = data_out_oe_n_i;
        write_enable_n_o = write_enable_n_o && !r;
        repeat (4) @(negedge ref_clk_i);
        chip_enable_o = 1'b0;
        @(negedge ref_clk_i);
        // Write enable returns high; the other released lines flip so stale values cannot pass
        write_enable_n_o = 1'b1;
        address_lines_o = ~a;
        chip_select_n_o = ~s;
        data_in_o = ~d;
        repeat (3) @(negedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

// file: tb/drk_dram_core_test.sv
/* Self-checking bench for the DRAM core.
   Assumes the controller model and the bound pin checker. */
`timescale 1ns/10ps
`default_nettype none
module drk_dram_core_test;
    localparam int REF_CYC = 16000;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce, cs_n, we_n, din, q, oe_n, dout, dout_oe_n, lost;
    logic [11:0] addr;
    logic        ref_bits [0:4095];
    logic        ref_known [0:4095] = '{default: 1'b0};
    // Code: address, deselect, write, read-then-write, data
    logic [15:0] corner [10] = '{16'h0005, 16'h0404, 16'hfff4, 16'h0000,
        16'h0001, 16'h040d, 16'h0400, 16'hfff3, 16'hfff0, 16'h0008};
    integer      seed = 47;
    int          bad_count = 0;
    int          checked = 0;

    always #5 ref_clk = ~ref_clk;

    drk_ctrl_model u_ctl (.ref_clk_i(ref_clk), .data_out_i(dout),
        .data_out_oe_n_i(dout_oe_n), .chip_enable_o(ce),
        .chip_select_n_o(cs_n), .write_enable_n_o(we_n),
        .address_lines_o(addr), .data_in_o(din));
    drk_dram_core #(.REFRESH_CYCLES(REF_CYC)) DUT (.ref_clk_i(ref_clk),
        .resetn_i(resetn), .chip_enable_i(ce), .chip_select_n_i(cs_n),
        .write_enable_n_i(we_n), .address_lines_i(addr),
        .data_in_i(din), .data_out_o(dout),
        .data_out_oe_n_o(dout_oe_n), .retention_lost_o(lost));
////////////////////////////////////////////////////////////////////////
    function automatic logic exp_out(input logic b);
        return ~b;
    endfunction

    task automatic cmp1(input string what, input logic e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic summarize;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic op(input logic [15:0] c);
        logic [11:0] a;
        logic        rd;
        a = c[15:4];
        rd = !c[3] && (!c[2] || c[1]);
        u_ctl.access(a, c[3], c[2], c[1], c[0], q, oe_n);
        cmp1("drive", !rd, oe_n);
        if (rd && ref_known[a])
            cmp1("data", exp_out(ref_bits[a]), q);
        if (!c[3] && (c[2] || c[1])) begin
            ref_bits[a] = c[0];
            ref_known[a] = 1'b1;
        end
    endtask

    // Deselected write-mode pulse on every row
    task automatic sweep;
        for (int r = 0; r < 64; r++)
            op({r[11:0], 4'b1100});
    endtask

    initial begin
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        foreach (corner[i])
            op(corner[i]);
        sweep();
        repeat (100)
            op(16'($random(seed)) & 16'h8c3f);
        sweep();
        cmp1("lost", 1'b0, lost);
        repeat (REF_CYC + 1200) @(negedge ref_clk);
        cmp1("lost", 1'b1, lost);
        summarize();
    end

    // About twice the expected run length
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
